// ### src/uicl_pkg.sv
// Package for the per-channel serial port control block
// Assumes an AXI4-Lite master with 32-bit data on the register side
package uicl_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [4:0] IDX_DATA = 5'h0_0;
  localparam logic [4:0] IDX_IEN  = 5'h0_1;
  localparam logic [4:0] IDX_IID  = 5'h0_2;
  localparam logic [4:0] IDX_LFC  = 5'h0_3;
  localparam logic [4:0] IDX_LST  = 5'h0_5;
  localparam logic [4:0] IDX_MST  = 5'h0_6;
  localparam int unsigned ADDR_W  = 5;
  // Interrupt identification codes
  localparam logic [3:0] IID_LINE = 4'h6;
  localparam logic [3:0] IID_TOUT = 4'hC;
  localparam logic [3:0] IID_RXD  = 4'h4;
  localparam logic [3:0] IID_TXE  = 4'h2;
  localparam logic [3:0] IID_MDM  = 4'h0;
  localparam logic [3:0] IID_NONE = 4'h1;
  // Trigger levels
  localparam logic [4:0] TRIG_0 = 5'h0_1;
  localparam logic [4:0] TRIG_1 = 5'h0_4;
  localparam logic [4:0] TRIG_2 = 5'h0_8;
  localparam logic [4:0] TRIG_3 = 5'h0_E;
  localparam int unsigned FIFO_DEPTH = 16;
  // Time-out: four characters plus twelve bit times
  localparam int unsigned TOUT_CHARS = 4;
  localparam int unsigned TOUT_BITS  = 12;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {UICL_IDLE, UICL_RESP} uicl_bus_t;
endpackage

// ### src/uicl_ctrl.sv
// Interrupt, FIFO control and line format control of one channel
// Assumes the receive/transmit datapath sits outside and reports events
//
// Overview of operation
// [RQ1] FIFOs on, enables off: host polls status
// [RQ2] Receive irq on character or trigger level
// [RQ3] Transmit irq on empty, also on enabling
// [RQ4] Overrun at once; errors when at head
// [RQ5] Identification shows highest pending source
// [RQ6] Time-out after four chars plus twelve bits
// [RQ7] Transmit source: holding register or FIFO empty
// [RQ8] Modem irq from deltas, cleared by read
// [RQ9] Line irq cleared by status read
// [RQ10] Transmit irq cleared by id read or write
// [RQ11] Identification codes per priority level
// [RQ12] Bits 7:6 show FIFO enable, 5:4 zero
// [RQ13] FIFO control ignored unless bit 0 set
// [RQ14] FIFO reset bits pulse then self clear
// [RQ15] Bit 3 selects DMA pin signalling
// [RQ16] Trigger codes give 1, 4, 8, 14
// [RQ17] Word length 5 to 8 bits
// [RQ18] Stop bits 1, 1.5 or 2
// [RQ19] Parity enable and odd/even select
// [RQ20] Forced parity mark or space
// [RQ21] Break holds transmit line low
// [RQ22] Bit 7 selects divisor latch registers
// [RQ23] Data ready set on entry, clear empty
// [RQ24] Time-out timer restarts, idle when empty
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module uicl_ctrl
  import uicl_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              RST,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  input  wire logic              RX_PUSH,
  input  wire logic              RX_HEAD_ERR,
  input  wire logic              RX_OVERRUN,
  input  wire logic              TX_POP,
  input  wire logic              TX_SHIFT_IDLE,
  input  wire logic [3:0]        MODEM_DELTA,
  input  wire logic              BIT_TICK,
  output logic                   IRQ,
  output logic                   RX_FIFO_RESET,
  output logic                   TX_FIFO_RESET,
  output logic [3:0]             DATA_BITS,
  output logic [1:0]             STOP_HALVES_EXTRA,
  output logic                   PARITY_ON,
  output logic                   PARITY_FORCED,
  output logic                   PARITY_VALUE_EVEN,
  output logic                   BREAK_LOW,
  output logic                   DIVISOR_SELECT,
  output logic                   DATA_WRITE,
  output logic                   DATA_READ,
  output logic                   RX_READY_PIN_N,
  output logic                   TX_READY_PIN_N
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] trig_level(input logic [1:0] code);
    case (code)
      2'h0:    trig_level = TRIG_0;
      2'h1:    trig_level = TRIG_1;
      2'h2:    trig_level = TRIG_2;
      default: trig_level = TRIG_3;
    endcase
  endfunction

  // Bit times per character incl. start, parity and stop
  function automatic logic [3:0] char_bits(input logic [7:0] lfc);
    logic [3:0] n;
    n = 4'h7 + {2'h0, lfc[1:0]} + {3'h0, lfc[3]} + {3'h0, lfc[2]};
    char_bits = n;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    uicl_bus_t  wst;
    uicl_bus_t  rst_;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [ADDR_W-1:0] awaddr;
    logic       aw_got;
    logic [31:0] wdata;
    logic       w_got;
    logic       w_lane0;
    logic [3:0] ien;
    logic [7:0] lfc;
    logic       fifo_on;
    logic       dma;
    logic [1:0] trig;
    logic       rx_rst;
    logic       tx_rst;
    logic [4:0] rx_cnt;
    logic [4:0] tx_cnt;
    logic       overrun;
    logic       err_held;
    logic [3:0] mdelta;
    logic       txe_irq;
    logic       tout;
    logic [6:0] tcnt;
    logic       data_wr;
    logic       data_rd;
  } uicl_state_t;

  uicl_state_t s;
  uicl_state_t next_s;

  logic [3:0] iid;
  logic       rd_fire;
  logic       wr_fire;
  logic [ADDR_W-1:0] ridx;
  logic [ADDR_W-1:0] widx;
  logic       rx_irq;
  logic       line_irq;
  logic       tx_empty;
  logic [6:0] tout_limit;

  assign ridx     = ARADDR >> 2;
  assign widx     = s.awaddr >> 2;
  assign rd_fire  = ARVALID && (s.rst_ == UICL_IDLE);
  assign wr_fire  = s.aw_got && s.w_got && (s.wst == UICL_IDLE);
  // Transmit source is holding register or FIFO empty
  assign tx_empty = (s.tx_cnt == 5'h0_0); // [RQ7]
  // Trigger level 1 in non-FIFO mode means one character held
  assign rx_irq   = s.fifo_on ? (s.rx_cnt >= trig_level(s.trig))
                              : (s.rx_cnt != 5'h0_0); // [RQ2] [RQ16]
  assign line_irq = s.overrun || s.err_held; // [RQ4]
  assign tout_limit = 7'(TOUT_CHARS) * {3'h0, char_bits(s.lfc)}
                    + 7'(TOUT_BITS); // [RQ6]

  // Priority encoder; all enables clear gives polled mode
  always_comb begin
    if (s.ien[2] && line_irq) begin
      iid = IID_LINE; // [RQ5] [RQ11] [RQ1]
    end else if (s.ien[0] && s.tout) begin
      iid = IID_TOUT;
    end else if (s.ien[0] && rx_irq) begin
      iid = IID_RXD;
    end else if (s.ien[1] && s.txe_irq) begin
      iid = IID_TXE;
    end else if (s.ien[3] && (s.mdelta != 4'h0)) begin
      iid = IID_MDM; // [RQ8]
    end else begin
      iid = IID_NONE;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.rx_rst  = 1'b0; // [RQ14]
    next_s.tx_rst  = 1'b0;
    next_s.data_wr = 1'b0;
    next_s.data_rd = 1'b0;
    // Write channels taken in either order
    if (AWVALID && !s.aw_got) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = AWADDR;
    end
    if (WVALID && !s.w_got) begin
      next_s.w_got = 1'b1;
      next_s.wdata = WDATA;
      next_s.w_lane0 = WSTRB[0];
    end
    // FIFO counters track datapath events
    if (RX_PUSH && s.rx_cnt != 5'(FIFO_DEPTH)) begin
      next_s.rx_cnt = s.rx_cnt + 5'h0_1; // [RQ23]
      next_s.tcnt   = 7'h0_0; // [RQ24]
    end
    if (TX_POP && s.tx_cnt != 5'h0_0) begin
      next_s.tx_cnt = s.tx_cnt - 5'h0_1;
      if (s.tx_cnt == 5'h0_1) begin
        next_s.txe_irq = 1'b1; // [RQ3]
      end
    end
    if (RX_OVERRUN) begin
      next_s.overrun = 1'b1;
    end
    next_s.err_held = RX_HEAD_ERR && (s.rx_cnt != 5'h0_0) ? 1'b1
                    : s.err_held;
    // Timer runs only while data waits
    if (s.rx_cnt == 5'h0_0) begin
      next_s.tcnt = 7'h0_0; // [RQ24]
    end else if (BIT_TICK && !RX_PUSH && !s.tout) begin
      if (s.tcnt + 7'h0_1 >= tout_limit) begin
        next_s.tout = 1'b1; // [RQ6]
      end
      next_s.tcnt = s.tcnt + 7'h0_1;
    end
    // Write path
    if (wr_fire) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.wst    = UICL_RESP;
      next_s.bresp  = RESP_OKAY;
      if (s.w_lane0) begin
        case (widx)
          IDX_DATA: begin
            if (!s.lfc[7]) begin
              next_s.data_wr = 1'b1;
              next_s.txe_irq = 1'b0; // [RQ10]
              if (s.tx_cnt != 5'(FIFO_DEPTH) &&
                  (s.fifo_on || s.tx_cnt == 5'h0_0)) begin
                next_s.tx_cnt = next_s.tx_cnt + 5'h0_1;
              end
            end
          end
          IDX_IEN: begin
            if (!s.lfc[7]) begin
              next_s.ien = s.wdata[3:0];
              if (s.wdata[1] && !s.ien[1] && tx_empty) begin
                next_s.txe_irq = 1'b1; // [RQ3]
              end
            end
          end
          IDX_IID: begin
            next_s.fifo_on = s.wdata[0]; // [RQ13]
            if (s.wdata[0]) begin
              next_s.rx_rst = s.wdata[1]; // [RQ14]
              next_s.tx_rst = s.wdata[2];
              next_s.dma    = s.wdata[3]; // [RQ15]
              next_s.trig   = s.wdata[7:6]; // [RQ16]
              if (s.wdata[1]) begin
                next_s.rx_cnt   = 5'h0_0;
                next_s.err_held = 1'b0;
                next_s.tout     = 1'b0;
              end
              if (s.wdata[2]) begin
                next_s.tx_cnt  = 5'h0_0;
                next_s.txe_irq = 1'b1;
              end
            end
          end
          IDX_LFC: next_s.lfc = s.wdata[7:0]; // [RQ17] [RQ22]
          default: ;
        endcase
      end
    end
    if (s.wst == UICL_RESP && BREADY) begin
      next_s.wst = UICL_IDLE;
    end
    // Read path
    if (rd_fire) begin
      next_s.rst_  = UICL_RESP;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      case (ridx)
        IDX_DATA: begin
          if (!s.lfc[7]) begin
            next_s.data_rd = 1'b1;
            next_s.tout    = 1'b0; // [RQ6]
            next_s.tcnt    = 7'h0_0; // [RQ24]
            next_s.err_held = 1'b0;
            if (s.rx_cnt != 5'h0_0 && next_s.rx_cnt != 5'h0_0) begin
              next_s.rx_cnt = next_s.rx_cnt - 5'h0_1; // [RQ23]
            end
          end
        end
        IDX_IEN: next_s.rdata[3:0] = s.lfc[7] ? 4'h0 : s.ien; // [RQ22]
        IDX_IID: begin
          next_s.rdata[7:0] = {{2{s.fifo_on}}, 2'h0, iid}; // [RQ12]
          // A last-character pop in the same cycle wins over the clear
          if (iid == IID_TXE && !(TX_POP && s.tx_cnt == 5'h0_1)) begin
            next_s.txe_irq = 1'b0; // [RQ10]
          end
        end
        IDX_LFC: next_s.rdata[7:0] = s.lfc;
        IDX_LST: begin
          next_s.rdata[7:0] = {s.err_held, tx_empty && TX_SHIFT_IDLE,
                               tx_empty, 2'h0, s.err_held, s.overrun,
                               s.rx_cnt != 5'h0_0}; // [RQ1] [RQ23]
          next_s.overrun  = RX_OVERRUN; // [RQ9]
          next_s.err_held = 1'b0;
        end
        IDX_MST: begin
          next_s.rdata[3:0] = s.mdelta;
          next_s.mdelta     = MODEM_DELTA; // [RQ8]
        end
        default: next_s.rresp = RESP_SLVERR;
      endcase
    end
    // Modem deltas set; a set in the read cycle survives
    if (!(rd_fire && ridx == IDX_MST)) begin
      next_s.mdelta = s.mdelta | MODEM_DELTA;
    end
    if (s.rst_ == UICL_RESP && RREADY) begin
      next_s.rst_ = UICL_IDLE;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign AWREADY = !s.aw_got;
  assign WREADY  = !s.w_got;
  assign BVALID  = (s.wst == UICL_RESP);
  assign BRESP   = s.bresp;
  assign ARREADY = (s.rst_ == UICL_IDLE);
  assign RVALID  = (s.rst_ == UICL_RESP);
  assign RDATA   = s.rdata;
  assign RRESP   = s.rresp;
  assign IRQ     = (iid != IID_NONE);
  assign RX_FIFO_RESET = s.rx_rst;
  assign TX_FIFO_RESET = s.tx_rst;
  assign DATA_WRITE    = s.data_wr;
  assign DATA_READ     = s.data_rd;
  assign DATA_BITS     = 4'h5 + {2'h0, s.lfc[1:0]}; // [RQ17]
  // Extra half stop bits: none with bit 2 clear; else 1 for 5-bit words, 2 otherwise
  assign STOP_HALVES_EXTRA = !s.lfc[2] ? 2'h0
                           : (s.lfc[1:0] == 2'h0) ? 2'h1 : 2'h2; // [RQ18]
  assign PARITY_ON         = s.lfc[3]; // [RQ19]
  assign PARITY_VALUE_EVEN = s.lfc[4];
  assign PARITY_FORCED     = s.lfc[3] && s.lfc[5]; // [RQ20]
  assign BREAK_LOW         = s.lfc[6]; // [RQ21]
  assign DIVISOR_SELECT    = s.lfc[7]; // [RQ22]
  // Normal mode: any data / empty; DMA mode with FIFOs on: trigger or time-out / not full
  assign RX_READY_PIN_N = !(s.dma && s.fifo_on ? rx_irq || s.tout
                                               : s.rx_cnt != 5'h0_0);
  assign TX_READY_PIN_N = !(s.dma && s.fifo_on
                            ? s.tx_cnt != 5'(FIFO_DEPTH)
                            : tx_empty); // [RQ15]

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_line_first: assert property (@(posedge CLOCK) disable iff (RST) // [RQ5]
    (s.ien[2] && line_irq) |-> iid == IID_LINE)
    else $error("Line status not reported first");
  a_iid_none: assert property (@(posedge CLOCK) disable iff (RST) // [RQ1]
    (s.ien == 4'h0) |-> iid == IID_NONE)
    else $error("Source reported with enables off");
  a_fifo_bits: assert property (@(posedge CLOCK) disable iff (RST) // [RQ12]
    (rd_fire && ridx == IDX_IID) |=>
      RDATA[7:4] == {{2{$past(s.fifo_on)}}, 2'h0})
    else $error("Identification upper bits wrong");
  a_fcr_gate: assert property (@(posedge CLOCK) disable iff (RST) // [RQ13]
    (wr_fire && widx == IDX_IID && s.w_lane0 && !s.wdata[0]) |=>
      $stable(s.trig) && !s.rx_rst)
    else $error("FIFO control taken without enable");
  a_rst_pulse: assert property (@(posedge CLOCK) disable iff (RST) // [RQ14]
    s.rx_rst |-> s.rx_cnt == 5'h0_0 ##1 !s.rx_rst)
    else $error("Receive reset did not self clear");
  a_txe_clear: assert property (@(posedge CLOCK) disable iff (RST) // [RQ10]
    (rd_fire && ridx == IDX_IID && iid == IID_TXE && !TX_POP) |=>
      !s.txe_irq)
    else $error("Transmit irq not cleared by id read");
  a_break_line: assert property (@(posedge CLOCK) disable iff (RST) // [RQ21]
    BREAK_LOW == s.lfc[6])
    else $error("Break output not following control");
  a_tout_clear: assert property (@(posedge CLOCK) disable iff (RST) // [RQ6]
    (rd_fire && ridx == IDX_DATA && !s.lfc[7]) |=> !s.tout)
    else $error("Time-out not cleared by data read");
  a_mdm_hold: assert property (@(posedge CLOCK) disable iff (RST) // [RQ8]
    (MODEM_DELTA != 4'h0) |=> s.mdelta != 4'h0)
    else $error("Modem delta lost");
  a_stop_len: assert property (@(posedge CLOCK) disable iff (RST) // [RQ18]
    (s.lfc[2] && s.lfc[1:0] == 2'h0) |-> STOP_HALVES_EXTRA == 2'h1)
    else $error("Stop length wrong for 5-bit words");

endmodule

// ### tb/uicl_far.sv
// Behavioural serial datapath standing behind the control block
// Assumes the bench requests receive pushes and overruns by one-cycle pulses, the head error by a held level
`timescale 1ns/100ps
module uicl_far (
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic       DATA_WRITE,
  input  wire logic       RX_REQ,
  input  wire logic       OVR_REQ,
  input  wire logic       ERR_LVL,
  input  wire logic [3:0] MDM_REQ,
  output logic            RX_PUSH,
  output logic            RX_HEAD_ERR,
  output logic            RX_OVERRUN,
  output logic            TX_POP,
  output logic            TX_SHIFT_IDLE,
  output logic [3:0]      MODEM_DELTA,
  output logic            BIT_TICK
);
  logic [1:0] div;
  logic [3:0] busy;
  // ----------------------------------------
  // One bit time every four clocks
  // ----------------------------------------
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      div         <= 2'h0;
      BIT_TICK    <= 1'b0;
      RX_PUSH     <= 1'b0;
      RX_OVERRUN  <= 1'b0;
      RX_HEAD_ERR <= 1'b0;
      MODEM_DELTA <= 4'h0;
      TX_POP      <= 1'b0;
      busy        <= 4'h0;
    end else begin
      div         <= div + 2'h1;
      BIT_TICK    <= (div == 2'h3);
      RX_PUSH     <= RX_REQ;
      RX_OVERRUN  <= OVR_REQ;
      RX_HEAD_ERR <= ERR_LVL;
      MODEM_DELTA <= MDM_REQ;
      // Shift register takes each written char at once
      TX_POP      <= DATA_WRITE;
      if (DATA_WRITE) begin
        busy <= 4'hF;
      end else if (busy != 4'h0) begin
        busy <= busy - 4'h1;
      end
    end
  end
  assign TX_SHIFT_IDLE = (busy == 4'h0);
endmodule

// ### tb/tb_uart_irq_fifo_line_control.sv
// Register-level bench of the channel control block
// Assumes the datapath model uicl_far on the event side
`timescale 1ns/100ps
module tb_uart_irq_fifo_line_control;
  import uicl_pkg::*;
  localparam logic [4:0] A_DAT = IDX_DATA << 2;
  localparam logic [4:0] A_IEN = IDX_IEN << 2;
  localparam logic [4:0] A_IID = IDX_IID << 2;
  localparam logic [4:0] A_LFC = IDX_LFC << 2;
  localparam logic [4:0] A_LST = IDX_LST << 2;
  localparam logic [4:0] A_MST = IDX_MST << 2;
  logic CLOCK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY, RX_PUSH, RX_HEAD_ERR;
  logic RX_OVERRUN, TX_POP, TX_SHIFT_IDLE, BIT_TICK, IRQ;
  logic RX_FIFO_RESET, TX_FIFO_RESET, PARITY_ON, PARITY_FORCED;
  logic PARITY_VALUE_EVEN, BREAK_LOW, DIVISOR_SELECT, DATA_WRITE;
  logic DATA_READ, RX_READY_PIN_N, TX_READY_PIN_N;
  logic rx_req, ovr_req, err_lvl;
  logic [4:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rv;
  logic [3:0]  WSTRB, MODEM_DELTA, DATA_BITS, mdm_req;
  logic [1:0]  BRESP, RRESP, STOP_HALVES_EXTRA, rr;
  int num_errors, checked, cyc, nrr, ntr, nrd, t0;
  // Start, five data bits and one stop bit per character
  localparam int TOUT_LIM = TOUT_CHARS * 7 + TOUT_BITS;

  uicl_ctrl DUT (.CLOCK(CLOCK), .RST(RST), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .RX_PUSH(RX_PUSH), .RX_HEAD_ERR(RX_HEAD_ERR),
    .RX_OVERRUN(RX_OVERRUN), .TX_POP(TX_POP),
    .TX_SHIFT_IDLE(TX_SHIFT_IDLE), .MODEM_DELTA(MODEM_DELTA),
    .BIT_TICK(BIT_TICK), .IRQ(IRQ), .RX_FIFO_RESET(RX_FIFO_RESET),
    .TX_FIFO_RESET(TX_FIFO_RESET), .DATA_BITS(DATA_BITS),
    .STOP_HALVES_EXTRA(STOP_HALVES_EXTRA), .PARITY_ON(PARITY_ON),
    .PARITY_FORCED(PARITY_FORCED), .PARITY_VALUE_EVEN(PARITY_VALUE_EVEN),
    .BREAK_LOW(BREAK_LOW), .DIVISOR_SELECT(DIVISOR_SELECT),
    .DATA_WRITE(DATA_WRITE), .DATA_READ(DATA_READ),
    .RX_READY_PIN_N(RX_READY_PIN_N), .TX_READY_PIN_N(TX_READY_PIN_N));

  uicl_far FAR (.CLOCK(CLOCK), .RST(RST), .DATA_WRITE(DATA_WRITE),
    .RX_REQ(rx_req), .OVR_REQ(ovr_req), .ERR_LVL(err_lvl),
    .MDM_REQ(mdm_req), .RX_PUSH(RX_PUSH), .RX_HEAD_ERR(RX_HEAD_ERR),
    .RX_OVERRUN(RX_OVERRUN), .TX_POP(TX_POP),
    .TX_SHIFT_IDLE(TX_SHIFT_IDLE), .MODEM_DELTA(MODEM_DELTA),
    .BIT_TICK(BIT_TICK));

  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end

  // ----------------------------------------
  // Watchdog, reset pulse and data read pulse counters
  // ----------------------------------------
  always @(posedge CLOCK) begin
    cyc++;
    if (RX_FIFO_RESET === 1'b1) nrr++;
    if (TX_FIFO_RESET === 1'b1) ntr++;
    if (DATA_READ === 1'b1) nrd++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic ck(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'b0;
    w  = 1'b0;
    @(posedge CLOCK);
    AWADDR  <= a;
    WDATA   <= {24'h00_0000, d};
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge CLOCK);
      if (!aw && AWREADY === 1'b1) begin
        aw = 1'b1;
        AWVALID <= 1'b0;
      end
      if (!w && WREADY === 1'b1) begin
        w = 1'b1;
        WVALID <= 1'b0;
      end
    end
    while (BVALID !== 1'b1) @(posedge CLOCK);
    BREADY <= 1'b0;
    @(negedge CLOCK);
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge CLOCK);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do @(posedge CLOCK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do @(posedge CLOCK); while (RVALID !== 1'b1);
    rv = RDATA;
    rr = RRESP;
    RREADY <= 1'b0;
  endtask

  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    rd(a);
    ck(rv[7:0], e);
  endtask

  task automatic push(input int n);
    repeat (n) begin
      @(posedge CLOCK);
      rx_req <= 1'b1;
      @(posedge CLOCK);
      rx_req <= 1'b0;
    end
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (IRQ !== 1'b1 && n < 300) begin
      @(posedge CLOCK);
      n++;
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {RST, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h3F & 6'h20;
    {rx_req, ovr_req, err_lvl} = 3'h0;
    {AWADDR, ARADDR, WDATA, mdm_req} = '0;
    WSTRB = 4'hF;
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    rc(A_IID, 8'h01);
    rc(A_LFC, 8'h00);
    rd(5'h1C);
    ck({6'h00, rr}, {6'h00, RESP_SLVERR});
    for (int i = 0; i < 4; i++) begin
      wr(A_LFC, 8'(i) | 8'h04);
      ck({4'h0, DATA_BITS}, 8'(5 + i));
      ck({6'h00, STOP_HALVES_EXTRA}, (i == 0) ? 8'h01 : 8'h02);
    end
    wr(A_LFC, 8'h38);
    ck({5'h00, PARITY_ON, PARITY_FORCED, PARITY_VALUE_EVEN}, 8'h07);
    wr(A_LFC, 8'h08);
    ck({5'h00, PARITY_ON, PARITY_FORCED, PARITY_VALUE_EVEN}, 8'h04);
    wr(A_LFC, 8'h40);
    ck({7'h00, BREAK_LOW}, 8'h01);
    wr(A_LFC, 8'h80);
    ck({7'h00, DIVISOR_SELECT}, 8'h01);
    rc(A_LFC, 8'h80);
    wr(A_LFC, 8'h00);
    ck({7'h00, BREAK_LOW}, 8'h00);
    wr(A_IID, 8'h06);
    ck(8'(nrr + ntr), 8'h00);
    rc(A_IID, 8'h01);
    wr(A_IID, 8'h07);
    ck(8'(nrr * 2 + ntr), 8'h03);
    rc(A_IID, 8'hC1);
    wr(A_IEN, 8'h02);
    ck({7'h00, IRQ}, 8'h01);
    rc(A_IID, 8'hC2);
    rc(A_IID, 8'hC1);
    wr(A_IEN, 8'h00);
    wr(A_IEN, 8'h02);
    ck({7'h00, IRQ}, 8'h01);
    rc(A_IID, 8'hC2);
    wr(A_DAT, 8'h55);
    repeat (4) @(posedge CLOCK);
    rc(A_IID, 8'hC2);
    wr(A_IEN, 8'h00);
    rc(A_IID, 8'hC1);
    wr(A_IID, 8'h41);
    wr(A_IEN, 8'h05);
    push(3);
    rc(A_IID, 8'hC1);
    push(1);
    rc(A_IID, 8'hC4);
    @(posedge CLOCK);
    ovr_req <= 1'b1;
    @(posedge CLOCK);
    ovr_req <= 1'b0;
    rc(A_IID, 8'hC6);
    rc(A_LST, 8'h63);
    rc(A_IID, 8'hC4);
    rd(A_DAT);
    t0 = cyc;
    rc(A_IID, 8'hC1);
    ck({7'h00, RX_READY_PIN_N}, 8'h00);
    wr(A_IID, 8'h49);
    ck({7'h00, RX_READY_PIN_N}, 8'h01);
    ck({7'h00, TX_READY_PIN_N}, 8'h00);
    repeat (90) @(posedge CLOCK);
    rc(A_IID, 8'hC1);
    wait_irq();
    t0 = cyc - t0;
    checked++;
    if (t0 < 4 * TOUT_LIM - 5 || t0 > 4 * TOUT_LIM + 2) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, t0,
               4 * TOUT_LIM);
    end
    rc(A_IID, 8'hCC);
    rd(A_DAT);
    rc(A_IID, 8'hC1);
    wr(A_IEN, 8'h08);
    @(posedge CLOCK);
    mdm_req <= 4'h4;
    @(posedge CLOCK);
    mdm_req <= 4'h0;
    rc(A_IID, 8'hC0);
    rd(A_MST);
    rc(A_IID, 8'hC1);
    wr(A_IEN, 8'h04);
    @(posedge CLOCK);
    err_lvl <= 1'b1;
    repeat (2) @(posedge CLOCK);
    rc(A_IID, 8'hC6);
    err_lvl <= 1'b0;
    rc(A_LST, 8'hE5);
    rc(A_IID, 8'hC1);
    ck(8'(nrd), 8'h02);
    end_sim();
  end
endmodule
